// File: hw/dual_mac_map.svh
// Register offsets, field positions, reset values and opcode constants of the dual MAC.
`ifndef DUAL_MAC_MAP_SVH
`define DUAL_MAC_MAP_SVH
`define DM_OFF_MODE 8'h00
`define DM_OFF_STATUS 8'h04
`define DM_OFF_COEF_PTR 8'h08
`define DM_REGION_ACC_LO 4'h1
`define DM_REGION_ACC_HI 4'h2
`define DM_MODE_FRACT 0
`define DM_MODE_SIGN 1
`define DM_MODE_MSAT 2
`define DM_MODE_WIDE 3
`define DM_MODE_RNDM 4
`define DM_MODE_SAT 5
`define DM_MODE_RESET 6'h02
`define DM_STATUS_BUSY 8
`define DM_PTR_RESET 16'h0000
`define DM_OP_PAIR_DATA 8'h82
`define DM_SUB_PAIR_DATA 2'b01
`define DM_OP_ONE_DATA 8'hfd
`define DM_SUB_ONE_DATA 6'h02
`define DM_MOD_INC 2'b01
`define DM_MOD_DEC 2'b10
`define DM_RESP_OKAY 2'b00
`define DM_RESP_SLVERR 2'b10
`define DM_ROUND_HALF 41'h000_0000_8000
`define DM_HALF_LSB 16'h8000
`define DM_SAT40_POS 40'h7f_ffff_ffff
`define DM_SAT40_NEG 40'h80_0000_0000
`define DM_SAT32_POS 40'h00_7fff_ffff
`define DM_SAT32_NEG 40'hff_8000_0000
`define DM_PROD_SAT 32'h7fff_ffff
`define DM_MIN_EXT 17'h1_8000
`endif

// File: hw/dual_mac_pkg.sv
// Types shared by the dual MAC datapath files.
package dual_mac_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REPEAT = 2'b01
  } exec_state_t;
  typedef logic [39:0] acc_t;
endpackage

// File: hw/dual_mac_decode.sv
// Opcode field decoder for the two paired multiply forms.
`timescale 1ns/1ps
`default_nettype none
`include "dual_mac_map.svh"
module dual_mac_decode (
  input wire logic [31:0] instr,
  output logic isPairData,
  output logic isOneData,
  output logic [1:0] firstAccSel,
  output logic [1:0] secondAccSel,
  output logic dataUns,
  output logic coefUns,
  output logic wideQual,
  output logic roundQual,
  output logic [1:0] coefModify
);
  // The two forms place the selects and unsigned flags differently; the wide and round qualifiers share bits 1 and 0, the modify field bits 9 and 8.
  assign isPairData = (instr[31:24] == `DM_OP_PAIR_DATA) &&
                      (instr[11:10] == `DM_SUB_PAIR_DATA);
  assign isOneData = (instr[31:24] == `DM_OP_ONE_DATA) &&
                     (instr[15:10] == `DM_SUB_ONE_DATA);
  assign coefModify = instr[9:8];
  assign firstAccSel = isOneData ? instr[7:6] : instr[5:4];
  assign secondAccSel = isOneData ? instr[5:4] : instr[3:2];
  assign dataUns = isOneData ? instr[3] : instr[7];
  assign coefUns = isOneData ? instr[2] : instr[6];
  assign wideQual = instr[1];
  assign roundQual = instr[0];
endmodule // dual_mac_decode
`default_nettype wire

// File: hw/dual_mac_unit.sv
// One multiplier path: extension, fractional shift, rounding, overflow and saturation.
`timescale 1ns/1ps
`default_nettype none
`include "dual_mac_map.svh"
module dual_mac_unit (
  input wire logic [15:0] dataIn,
  input wire logic [15:0] coefIn,
  input wire logic dataUns,
  input wire logic coefUns,
  input wire logic accumulate,
  input wire logic [39:0] accIn,
  input wire logic fractionalMode,
  input wire logic signExtensionMode,
  input wire logic multiplySaturationMode,
  input wire logic wideOverflowMode,
  input wire logic roundingMethod,
  input wire logic saturationEnable,
  input wire logic roundQual,
  output logic [39:0] result,
  output logic overflow
);
  logic [16:0] dataExt;
  logic [16:0] coefExt;
  logic signed [33:0] prod;
  logic [33:0] prodShift;
  logic prodSat;
  logic [31:0] prod32;
  logic [40:0] sum;
  logic [40:0] rsum;
  logic [40:0] rounded;
  logic halfTie;
  logic ovf32;
  logic ovf40;

  // Unsigned operands are zero extended, others follow the sign extension mode.
  assign dataExt = {~dataUns & signExtensionMode & dataIn[15], dataIn};
  assign coefExt = {~coefUns & signExtensionMode & coefIn[15], coefIn};
  assign prod = $signed(dataExt) * $signed(coefExt);
  assign prodShift = fractionalMode ? {prod[32:0], 1'b0} : prod;
  // Among sign-extended operands, only the minus-one squared case can leave the 32-bit range in fractional mode.
  assign prodSat = multiplySaturationMode & fractionalMode &
                   (dataExt == `DM_MIN_EXT) & (coefExt == `DM_MIN_EXT);
  assign prod32 = prodSat ? `DM_PROD_SAT : prodShift[31:0];

  // The sum keeps a 41st bit so a 40-bit overflow is still visible.
  assign sum = (accumulate ? {accIn[39], accIn} : 41'h0) +
               {{9{prod32[31]}}, prod32};
  assign rsum = sum + `DM_ROUND_HALF;
  assign halfTie = roundingMethod & (sum[15:0] == `DM_HALF_LSB);
  assign rounded = roundQual ? {rsum[40:17], rsum[16] & ~halfTie, 16'h0000} : sum;

  // Wide mode compares bit 40 with bit 39, narrow mode checks that bits 40 down to 31 all agree.
  assign ovf40 = rounded[40] ^ rounded[39];
  assign ovf32 = ~((&rounded[40:31]) | ~(|rounded[40:31]));
  assign overflow = wideOverflowMode ? ovf40 : ovf32;

  // Without saturation the value simply wraps, which some filters rely on.
  always_comb begin
    result = rounded[39:0];
    if (saturationEnable && overflow) begin
      if (wideOverflowMode) begin
        result = rounded[40] ? `DM_SAT40_NEG : `DM_SAT40_POS;
      end else begin
        result = rounded[40] ? `DM_SAT32_NEG : `DM_SAT32_POS;
      end
    end
  end
endmodule // dual_mac_unit
`default_nettype wire

// File: hw/dual_mac_parallel_multiply.sv
// Dual multiply-accumulate datapath with an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dual_mac_map.svh"
module dual_mac_parallel_multiply (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [7:0] repeatCount,
  input wire logic xModifyOnly,
  input wire logic yModifyOnly,
  input wire logic [15:0] xPathDataBus,
  input wire logic [15:0] yPathData,
  input wire logic [15:0] coefficientBus,
  input wire logic [15:0] highCoefficientBus,
  input wire logic [15:0] lowCoefficientBus,
  output logic [15:0] coefficientAddressBus,
  output logic [15:0] lowCoefAddress,
  output logic busy,
  output logic auxUpdateX,
  output logic auxUpdateY,
  output logic [3:0] overflowFlags
);
  logic rstSync1;
  logic rstN;
  dual_mac_pkg::exec_state_t stateReg;
  dual_mac_pkg::exec_state_t stateNext;
  logic [31:0] heldInstrReg;
  logic [7:0] repeatLeftReg;
  logic [7:0] repeatLeftNext;
  logic [5:0] modeReg;
  logic [5:0] modeNext;
  logic [15:0] ptrReg;
  logic [15:0] ptrNext;
  dual_mac_pkg::acc_t accReg [4];
  dual_mac_pkg::acc_t accNext [4];
  logic [3:0] ovfReg;
  logic [3:0] ovfNext;
  logic [7:0] awAddrReg;
  logic awHaveReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic wHaveReg;

  // The reset is released through two flops so every reset register leaves reset together.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstN <= rstSync1;
    end
  end

  // Instruction selection: a repeat iteration reuses the held word, never the port.
  wire isIdle = (stateReg == dual_mac_pkg::ST_IDLE);
  wire [31:0] execWord = isIdle ? instrWord : heldInstrReg;
  wire isPairData;
  wire isOneData;
  wire [1:0] firstAccSel;
  wire [1:0] secondAccSel;
  wire dataUns;
  wire coefUns;
  wire wideQual;
  wire roundQual;
  wire [1:0] coefModify;

  dual_mac_decode u_decode (
    .instr(execWord),
    .isPairData(isPairData),
    .isOneData(isOneData),
    .firstAccSel(firstAccSel),
    .secondAccSel(secondAccSel),
    .dataUns(dataUns),
    .coefUns(coefUns),
    .wideQual(wideQual),
    .roundQual(roundQual),
    .coefModify(coefModify)
  );

  wire formOk = isPairData | isOneData;
  wire execValid = formOk & (instrValid | ~isIdle);
  wire startRepeat = isIdle & execValid & (repeatCount != 8'h00);
  wire wideEff = modeReg[`DM_MODE_WIDE] | wideQual;

  // Operand steering: the single-data form shares the X path word with both units.
  wire [15:0] unitData [2];
  wire [15:0] unitCoef [2];
  wire [39:0] unitAcc [2];
  wire [39:0] unitResult [2];
  wire unitOvf [2];
  assign unitData[0] = xPathDataBus;
  assign unitData[1] = isOneData ? xPathDataBus : yPathData;
  assign unitCoef[0] = isOneData ? highCoefficientBus : coefficientBus;
  assign unitCoef[1] = isOneData ? lowCoefficientBus : coefficientBus;
  assign unitAcc[0] = accReg[firstAccSel];
  assign unitAcc[1] = accReg[secondAccSel];

  // Unit 0 accumulates into its destination, unit 1 writes its product alone.
  for (genvar gu = 0; gu < 2; gu++) begin : g_unit
    dual_mac_unit u_unit (
      .dataIn(unitData[gu]),
      .coefIn(unitCoef[gu]),
      .dataUns(dataUns),
      .coefUns(coefUns),
      .accumulate(gu == 0),
      .accIn(unitAcc[gu]),
      .fractionalMode(modeReg[`DM_MODE_FRACT]),
      .signExtensionMode(modeReg[`DM_MODE_SIGN]),
      .multiplySaturationMode(modeReg[`DM_MODE_MSAT]),
      .wideOverflowMode(wideEff),
      .roundingMethod(modeReg[`DM_MODE_RNDM]),
      .saturationEnable(modeReg[`DM_MODE_SAT]),
      .roundQual(roundQual),
      .result(unitResult[gu]),
      .overflow(unitOvf[gu])
    );
  end

  // A modify-only path keeps its address update but suppresses its accumulator write.
  wire writeFirst = execValid & ~xModifyOnly;
  wire writeSecond = execValid & ~yModifyOnly;

  // Repeat sequencing: the count says how many extra iterations follow the first.
  always_comb begin
    stateNext = stateReg;
    repeatLeftNext = repeatLeftReg;
    case (stateReg)
      dual_mac_pkg::ST_IDLE: begin
        if (startRepeat) begin
          stateNext = dual_mac_pkg::ST_REPEAT;
          repeatLeftNext = repeatCount;
        end
      end
      dual_mac_pkg::ST_REPEAT: begin
        repeatLeftNext = repeatLeftReg - 8'h01;
        if (repeatLeftReg == 8'h01) begin
          stateNext = dual_mac_pkg::ST_IDLE;
        end
      end
      default: begin
        stateNext = dual_mac_pkg::ST_IDLE;
      end
    endcase
  end

  // Write side decoding over the latched address and strobe-merged data.
  wire wrDo = awHaveReg & wHaveReg & ~bvalid;
  wire [31:0] strobeMask;
  for (genvar gb = 0; gb < 4; gb++) begin : g_strobe
    assign strobeMask[8*gb +: 8] = {8{wStrbReg[gb]}};
  end
  wire wrAligned = (awAddrReg[1:0] == 2'b00);
  wire wrMode = wrDo & (awAddrReg == `DM_OFF_MODE);
  wire wrStatus = wrDo & (awAddrReg == `DM_OFF_STATUS);
  wire wrPtr = wrDo & (awAddrReg == `DM_OFF_COEF_PTR);
  wire wrAccLo = wrAligned & (awAddrReg[7:4] == `DM_REGION_ACC_LO);
  wire wrAccHi = wrAligned & (awAddrReg[7:4] == `DM_REGION_ACC_HI);
  wire wrKnown = wrMode | wrStatus | wrPtr | (wrDo & (wrAccLo | wrAccHi));
  wire [31:0] wrClear = wDataReg & strobeMask;

  // Pointer stepping: the paired-coefficient form moves by a whole long word.
  wire [15:0] ptrStep = isOneData ? 16'h0002 : 16'h0001;
  always_comb begin
    ptrNext = ptrReg;
    if (wrPtr) begin
      ptrNext = (ptrReg & ~strobeMask[15:0]) | (wDataReg[15:0] & strobeMask[15:0]);
    end
    if (execValid && coefModify == `DM_MOD_INC) begin
      ptrNext = ptrReg + ptrStep;
    end else if (execValid && coefModify == `DM_MOD_DEC) begin
      ptrNext = ptrReg - ptrStep;
    end
  end
  assign modeNext = wrMode ? ((modeReg & ~strobeMask[5:0]) | (wDataReg[5:0] & strobeMask[5:0]))
                           : modeReg;

  // Per accumulator: the accumulating path wins a shared destination, then software.
  for (genvar ga = 0; ga < 4; ga++) begin : g_acc
    wire hitFirst = writeFirst & (firstAccSel == ga);
    wire hitSecond = writeSecond & (secondAccSel == ga);
    wire swLo = wrDo & wrAccLo & (awAddrReg[3:2] == ga);
    wire swHi = wrDo & wrAccHi & (awAddrReg[3:2] == ga);
    wire [39:0] swMerged = {swHi ? ((accReg[ga][39:32] & ~strobeMask[7:0]) |
                                    (wDataReg[7:0] & strobeMask[7:0])) : accReg[ga][39:32],
                            swLo ? ((accReg[ga][31:0] & ~strobeMask) | (wDataReg & strobeMask))
                                 : accReg[ga][31:0]};
    assign accNext[ga] = hitFirst ? unitResult[0] :
                         hitSecond ? unitResult[1] : swMerged;
    // Hardware setting a flag beats a write-one-to-clear in the same cycle.
    assign ovfNext[ga] = (hitFirst & unitOvf[0]) | (hitSecond & unitOvf[1]) |
                         (ovfReg[ga] & ~(wrStatus & wrClear[ga]));
  end

  // Datapath state and the coefficient address outputs.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stateReg <= dual_mac_pkg::ST_IDLE;
      repeatLeftReg <= 8'h00;
      heldInstrReg <= 32'h0000_0000;
      modeReg <= `DM_MODE_RESET;
      ptrReg <= `DM_PTR_RESET;
      ovfReg <= 4'h0;
      busy <= 1'b0;
      auxUpdateX <= 1'b0;
      auxUpdateY <= 1'b0;
      coefficientAddressBus <= `DM_PTR_RESET;
      lowCoefAddress <= `DM_PTR_RESET ^ 16'h0001;
      overflowFlags <= 4'h0;
    end else begin
      stateReg <= stateNext;
      repeatLeftReg <= repeatLeftNext;
      if (startRepeat) begin
        heldInstrReg <= instrWord;
      end
      modeReg <= modeNext;
      ptrReg <= ptrNext;
      ovfReg <= ovfNext;
      busy <= (stateNext == dual_mac_pkg::ST_REPEAT);
      auxUpdateX <= execValid;
      auxUpdateY <= execValid & isPairData;
      coefficientAddressBus <= ptrNext;
      lowCoefAddress <= ptrNext ^ 16'h0001;
      overflowFlags <= ovfNext;
    end
  end

  // Accumulators have no reset: software loads them before use.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      accReg[i] <= accNext[i];
    end
  end

  // Write channel handshake: address and data are latched independently.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHaveReg <= 1'b0;
      wHaveReg <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `DM_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awHaveReg <= 1'b1;
        awAddrReg <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wHaveReg <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end
      if (wrDo) begin
        awHaveReg <= 1'b0;
        wHaveReg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrKnown ? `DM_RESP_OKAY : `DM_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read decoding happens on the request address; data is registered with rvalid.
  wire rdAligned = (araddr[1:0] == 2'b00);
  wire rdAccLo = rdAligned & (araddr[7:4] == `DM_REGION_ACC_LO);
  wire rdAccHi = rdAligned & (araddr[7:4] == `DM_REGION_ACC_HI);
  wire rdMode = (araddr == `DM_OFF_MODE);
  wire rdStatus = (araddr == `DM_OFF_STATUS);
  wire rdPtr = (araddr == `DM_OFF_COEF_PTR);
  wire rdKnown = rdMode | rdStatus | rdPtr | rdAccLo | rdAccHi;
  wire [39:0] rdAcc = accReg[araddr[3:2]];
  wire [31:0] statusWord = {23'h0, busy, 4'h0, ovfReg};
  wire [31:0] rdValue = rdMode ? {26'h0, modeReg} :
                        rdStatus ? statusWord :
                        rdPtr ? {16'h0, ptrReg} :
                        rdAccLo ? rdAcc[31:0] :
                        rdAccHi ? {24'h0, rdAcc[39:32]} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DM_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdValue;
        rresp <= rdKnown ? `DM_RESP_OKAY : `DM_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule // dual_mac_parallel_multiply
`default_nettype wire

// File: tb/dual_mac_checker.sv
// Port-level assertions for the dual MAC datapath, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module dual_mac_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [7:0] repeatCount,
  input wire logic busy,
  input wire logic auxUpdateX,
  input wire logic auxUpdateY,
  input wire logic [15:0] coefficientAddressBus,
  input wire logic [15:0] lowCoefAddress,
  input wire logic [3:0] overflowFlags
);
  // An instruction is taken only while idle and only for a known opcode form.
  wire pairOp = instrWord[31:24] == 8'h82 && instrWord[11:10] == 2'b01;
  wire oneOp = instrWord[31:24] == 8'hfd && instrWord[15:10] == 6'h02;
  wire start = instrValid && !busy && (pairOp || oneOp);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  busy_span_a: assert property (start |=> busy == ($past(repeatCount) != 8'h00))
    else $error("busy does not follow the repeat count");
  repeat_end_a: assert property (start && repeatCount == 8'h01 |=> busy ##1 !busy)
    else $error("single repeat does not end after one cycle");
  aux_pulse_a: assert property (start && repeatCount == 8'h00
    |=> auxUpdateX ##1 (!auxUpdateX || $past(start)))
    else $error("address update pulse missing or too long");
  aux_form_a: assert property (start |=> auxUpdateY == $past(pairOp))
    else $error("second address update does not match the form");
  low_addr_a: assert property (lowCoefAddress == (coefficientAddressBus ^ 16'h0001))
    else $error("low coefficient address is not the neighbour");
  ptr_two_a: assert property (start && oneOp && instrWord[9:8] == 2'b01
    |=> coefficientAddressBus == $past(coefficientAddressBus) + 16'h0002)
    else $error("paired pointer did not advance by two");
  ptr_back_a: assert property (start && pairOp && instrWord[9:8] == 2'b10
    |=> coefficientAddressBus == $past(coefficientAddressBus) - 16'h0001)
    else $error("pointer did not step back by one");
  flag_keep_a: assert property (awready && !awvalid
    |=> (overflowFlags & $past(overflowFlags)) == $past(overflowFlags))
    else $error("overflow flag dropped without a clear");
  flag_time_a: assert property (!start && !busy && awready && !awvalid
    |=> $stable(overflowFlags))
    else $error("overflow flags moved without an instruction");
  cover property (start && pairOp);
  cover property (start && oneOp ##1 busy);
  cover property (overflowFlags != 4'h0);
endmodule // dual_mac_checker
bind dual_mac_parallel_multiply dual_mac_checker chk (.clk(clk), .arst_n(arst_n),
  .awvalid(awvalid), .awready(awready), .instrValid(instrValid), .instrWord(instrWord),
  .repeatCount(repeatCount), .busy(busy), .auxUpdateX(auxUpdateX), .auxUpdateY(auxUpdateY),
  .coefficientAddressBus(coefficientAddressBus), .lowCoefAddress(lowCoefAddress),
  .overflowFlags(overflowFlags));
`default_nettype wire

// File: tb/coef_store.sv
// On-chip coefficient memory that answers the datapath's coefficient addresses.
`timescale 1ns/1ps
`default_nettype none
module coef_store (
  input wire logic [15:0] coefAddr,
  input wire logic [15:0] lowAddr,
  output logic [15:0] coefWord,
  output logic [15:0] highWord,
  output logic [15:0] lowWord
);
  logic [15:0] mem [16];
  // Entry zero holds the most negative word so the product clamp gets exercised.
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h8000 + 16'(i * 16'h1357);
  // Coefficients live in internal memory only, so reads never stall or fault.
  assign coefWord = mem[coefAddr[3:0]];
  assign highWord = mem[coefAddr[3:0]];
  assign lowWord = mem[lowAddr[3:0]];
endmodule // coef_store
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the dual MAC datapath against a reference model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr, araddr, repeatCount;
  logic [31:0] wdata, instrWord, rdata, q, lo, w;
  logic awvalid, wvalid, bready, arvalid, rready, instrValid, xModifyOnly, yModifyOnly;
  logic awready, wready, bvalid, arready, rvalid, busy, auxUpdateX, auxUpdateY;
  logic [1:0] bresp, rresp, f, s;
  logic [15:0] xPathDataBus, yPathData, coefWord, highWord, lowWord, coefAddr, lowAddr, ptr;
  logic [3:0] overflowFlags, flags;
  logic [39:0] acc [4];
  logic [5:0] mode;
  int failures = 0;
  int compares = 0;

  // Core clock at 100 MHz.
  always #5 clk = ~clk;

  dual_mac_parallel_multiply DUT (.clk(clk), .arst_n(arst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .instrValid(instrValid), .instrWord(instrWord),
    .repeatCount(repeatCount), .xModifyOnly(xModifyOnly), .yModifyOnly(yModifyOnly),
    .xPathDataBus(xPathDataBus), .yPathData(yPathData), .coefficientBus(coefWord),
    .highCoefficientBus(highWord), .lowCoefficientBus(lowWord),
    .coefficientAddressBus(coefAddr), .lowCoefAddress(lowAddr), .busy(busy),
    .auxUpdateX(auxUpdateX), .auxUpdateY(auxUpdateY), .overflowFlags(overflowFlags));

  coef_store cm (.coefAddr(coefAddr), .lowAddr(lowAddr), .coefWord(coefWord),
    .highWord(highWord), .lowWord(lowWord));

  // Every comparison is counted; a mismatch is reported at once.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One AXI4-Lite transfer; each channel is released at the edge that takes it.
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    bit ta, tw, td;
    logic [1:0] r;
    @(posedge clk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      // Inputs move only at rising edges, so the low phase shows what the next edge sees.
      @(negedge clk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      td = wr ? bvalid : rvalid;
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw) wvalid <= 1'b0;
    end while (!td);
    bready <= 1'b0;
    rready <= 1'b0;
    check(r, er);
  endtask

  // One multiplier path; the bit above the 40-bit result is its overflow.
  function automatic logic [40:0] unit(input logic [15:0] d, c, input bit du, cu,
    input logic [39:0] a, input bit wq, rq);
    longint x, y, p, t, h;
    x = (du || !mode[1]) ? longint'(d) : longint'($signed(d));
    y = (cu || !mode[1]) ? longint'(c) : longint'($signed(c));
    p = x * y;
    if (mode[0]) p = p <<< 1;
    if (mode[0] && mode[2] && x == -32768 && y == -32768) p = 64'h7fff_ffff;
    t = longint'($signed(a)) + longint'($signed(p[31:0]));
    if (rq) begin
      p = t & 64'hffff;
      t = (t + 32768) & -65536;
      if (mode[4] && p == 32768) t[16] = 1'b0;
    end
    h = (mode[3] || wq) ? 64'h7f_ffff_ffff : 64'h7fff_ffff;
    p = t;
    if ((t > h || t < -h - 1) && mode[5]) p = (t < 0) ? -h - 1 : h;
    return {t > h || t < -h - 1, p[39:0]};
  endfunction

  // Both paths, the flags and the coefficient pointer advance together.
  task automatic step(input logic [31:0] iw, input logic [15:0] x, y, input bit xm, ym);
    bit one, du, cu;
    logic [1:0] fa, sa;
    logic [15:0] hc, lc;
    logic [40:0] r1, r2;
    one = iw[31:24] == 8'hfd;
    fa = one ? iw[7:6] : iw[5:4];
    sa = one ? iw[5:4] : iw[3:2];
    du = one ? iw[3] : iw[7];
    cu = one ? iw[2] : iw[6];
    hc = cm.mem[ptr[3:0]];
    lc = one ? cm.mem[ptr[3:0] ^ 4'h1] : hc;
    r1 = unit(x, hc, du, cu, acc[fa], iw[1], iw[0]);
    r2 = unit(one ? x : y, lc, du, cu, 40'h0, iw[1], iw[0]);
    if (!ym) begin
      acc[sa] = r2[39:0];
      flags[sa] |= r2[40];
    end
    if (!xm) begin
      acc[fa] = r1[39:0];
      flags[fa] |= r1[40];
    end
    if (iw[9:8] == 2'b01) ptr += one ? 16'h2 : 16'h1;
    if (iw[9:8] == 2'b10) ptr -= one ? 16'h2 : 16'h1;
  endtask

  // One instruction and its repeat iterations, with fresh operands each cycle.
  task automatic issue(input logic [31:0] iw, input int n);
    logic [15:0] x, y;
    bit xm, ym;
    for (int i = 0; i <= n; i++) begin
      x = ($urandom % 4 == 0) ? 16'h8000 : 16'($urandom);
      y = 16'($urandom);
      xm = $urandom % 6 == 0;
      ym = $urandom % 6 == 0;
      @(posedge clk);
      instrValid <= i == 0;
      instrWord <= iw;
      repeatCount <= 8'(n);
      xPathDataBus <= x;
      yPathData <= y;
      xModifyOnly <= xm;
      yModifyOnly <= ym;
      if (iw[31:24] != 8'h00) step(iw, x, y, xm, ym);
    end
    @(posedge clk);
    instrValid <= 1'b0;
    xModifyOnly <= 1'b0;
    yModifyOnly <= 1'b0;
  endtask

  // Reset values, an unmapped place, then randomised instructions.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, instrValid, xModifyOnly, yModifyOnly} = '0;
    {awaddr, araddr, repeatCount, wdata, instrWord, xPathDataBus, yPathData} = '0;
    void'($urandom(32'hb22d9d5e));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0, 2'b00);
      check(q, i == 0 ? 32'h2 : 32'h0);
    end
    bus(1'b0, 8'h40, 32'h0, 2'b10);
    check(q, 32'h0);
    bus(1'b1, 8'h40, 32'h1234, 2'b10);
    for (int t = 0; t < 50; t++) begin
      mode = 6'($urandom);
      flags = 4'h0;
      ptr = 16'($urandom);
      bus(1'b1, 8'h00, {26'h0, mode}, 2'b00);
      bus(1'b1, 8'h04, 32'hf, 2'b00);
      bus(1'b1, 8'h08, {16'h0, ptr}, 2'b00);
      for (int i = 0; i < 4; i++) begin
        q = $urandom;
        acc[i] = {($urandom % 2) ? 8'($urandom) : {8{q[31]}}, q};
        bus(1'b1, 8'(16 + 4 * i), acc[i][31:0], 2'b00);
        bus(1'b1, 8'(32 + 4 * i), {24'h0, acc[i][39:32]}, 2'b00);
      end
      f = 2'($urandom);
      s = f ^ 2'($urandom_range(1, 3));
      case ($urandom % 4)
        0: w = {8'h00, 24'($urandom)};
        1: w = {8'hfd, 8'($urandom), 6'h02, 2'($urandom), f, s, 4'($urandom)};
        default: w = {8'h82, 12'($urandom), 2'b01, 4'($urandom), f, s, 2'($urandom)};
      endcase
      issue(w, $urandom % 4);
      @(negedge clk);
      check(coefAddr, ptr);
      check(lowAddr, ptr ^ 16'h1);
      check(overflowFlags, flags);
      bus(1'b0, 8'h00, 32'h0, 2'b00);
      check(q, {26'h0, mode});
      for (int i = 0; i < 4; i++) begin
        bus(1'b0, 8'(16 + 4 * i), 32'h0, 2'b00);
        lo = q;
        bus(1'b0, 8'(32 + 4 * i), 32'h0, 2'b00);
        check({q[7:0], lo}, acc[i]);
      end
    end
    results();
  end

  // Cut a hang short; the tests need well under this span.
  initial begin
    #500us;
    failures++;
    results();
  end
endmodule // testbench
`default_nettype wire
